// ===== hdl/parity_consts.svh
// Purpose: named constants for the memory parity and NMI logic
// Assumes: 32-bit memory data bus split into four bytes
// Notes:   definitions only
`ifndef PARITY_CONSTS_SVH
`define PARITY_CONSTS_SVH
`define DATA_W        32
`define LANES         4
`define LANE_W        8
`define LANE_NONE     4'h0
`define LANE_ALL_OFF  4'hF
`define NMI_OFF_RST   1'b1
`define PFLT_IDLE     1'b1
`define OE_OFF        1'b1
`define SYNC_CLR      3'h0
`define SYNC_SET      3'h7
`endif

// ===== hdl/parity_pkg.sv
// Purpose: shared types for the memory parity and NMI logic
// Assumes: included constants header supplies widths
// Notes:   types only
`include "parity_consts.svh"
package parity_pkg;
   typedef logic [`DATA_W-1:0] word_t;
   typedef logic [`LANES-1:0]  lane_t;
   // read-cycle tracking states, gray along idle -> read -> fault
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_FAULT = 2'b11
   } chk_state_e;
endpackage

// ===== hdl/parity_lane_if.sv
// Purpose: carries per-lane parity generation and check results
// Assumes: single clock domain
// Notes:   joins the top with the parity calculator
`timescale 1ns/1ns
`default_nettype none
interface parity_lane_if;
   import parity_pkg::*;
   word_t data;      // byte data to examine
   lane_t par_in;    // parity bits seen on the lines
   lane_t gen;       // odd parity generated per byte
   lane_t mismatch;  // per-byte parity disagreement
   modport calc (input data, input par_in, output gen, output mismatch);
   modport user (output data, output par_in, input gen, input mismatch);
endinterface
`default_nettype wire

// ===== hdl/parity_calc.sv
// Purpose: odd parity generation and comparison per memory byte
// Assumes: purely combinational
// Notes:   one instance covers all four lanes
`timescale 1ns/1ns
`default_nettype none
`include "parity_consts.svh"
module parity_calc
   import parity_pkg::*;
(
   // lane signals
   parity_lane_if.calc lanes
);
   // odd parity bit: makes ones in byte plus bit odd
   function automatic logic odd_bit(input logic [`LANE_W-1:0] b);
      odd_bit = ~(^b);
   endfunction

   // per-lane generate and compare
   always_comb begin
      for (int i = 0; i < `LANES; i++) begin
         lanes.gen[i]      = odd_bit(lanes.data[i*`LANE_W +: `LANE_W]);
         lanes.mismatch[i] = lanes.gen[i] ^ lanes.par_in[i];
      end
   end
endmodule
`default_nettype wire

// ===== hdl/memory_parity_nmi_logic.sv
// Purpose: byte parity on the memory data bus with channel check and NMI
// Assumes: memory controller marks read and write cycles with strobes
// Notes:   parity, data, check-enable, read and channel check pins pass three flops before use
//          data and parity lines three-state whenever no write is in progress
// What this block does
// - on memory reads, sample four parity lines and check each enabled byte
// - on memory writes, drive four parity lines with generated parity
// - controller gives active-low per-byte check enables; check only enabled bytes
// - parity error on a memory read asserts the active-low fault output
// - NMI out low when channel check or fault active and NMI enabled
// - NMI disable state is visible; reading 1 means NMI disabled
// - reset clears state, drives outputs inactive, releases data lines
`timescale 1ns/1ns
`default_nettype none
`include "parity_consts.svh"
module memory_parity_nmi_logic
   import parity_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic system_reset_in,
   // memory data bus
   input  wire word_t memory_data_in,
   output logic  [`DATA_W-1:0] memory_data_out,
   output logic  memory_data_oe_n,
   input  wire word_t write_data,
   // parity lines
   input  wire lane_t byte_parity_in,
   output logic  [`LANES-1:0] byte_parity_out,
   output logic  byte_parity_oe_n,
   // cycle control from memory controller
   input  wire logic mem_read,
   input  wire logic mem_write,
   input  wire lane_t byte_check_enable_n,
   // channel check and NMI
   input  wire logic channel_check_in_n,
   output logic  parity_fault_out_n,
   input  wire logic nmi_disable_set,
   input  wire logic nmi_disable_clr,
   output logic  nmi_disabled,
   output logic  nmi_out,
   output logic  nmi_oe_n,
   output logic  fault_clear_ack
);
   // synchroniser stages, filtered levels and the read tracker
   chk_state_e state_q;
   lane_t      par_s1_q, par_s2_q, par_s3_q;
   lane_t      en_s1_q, en_s2_q, en_s3_q;
   word_t      md_s1_q, md_s2_q, md_s3_q;
   logic [2:0] rd_s_q, chk_s_q;
   logic       rd_q, chk_q;
   logic       fault_q, nmi_off_q;
   logic       any_err;
   logic       sys_rst;
   // one calculator for the sampled read word, one for the outgoing write word
   parity_lane_if lanes_rd ();
   parity_lane_if lanes_wr ();

   // system reset already sits on this clock; it takes effect at the next edge
   assign sys_rst = system_reset_in;

   // three-stage sync of the parity lines and the per-byte check enables
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         par_s1_q <= `LANE_NONE;
         par_s2_q <= `LANE_NONE;
         par_s3_q <= `LANE_NONE;
         en_s1_q  <= `LANE_ALL_OFF;
         en_s2_q  <= `LANE_ALL_OFF;
         en_s3_q  <= `LANE_ALL_OFF;
      end else begin
         par_s1_q <= byte_parity_in;
         par_s2_q <= par_s1_q;
         par_s3_q <= par_s2_q;
         en_s1_q  <= byte_check_enable_n;
         en_s2_q  <= en_s1_q;
         en_s3_q  <= en_s2_q;
      end
   end

   // three-stage sync of the memory data, in step with the parity lines
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         md_s1_q <= '0;
         md_s2_q <= '0;
         md_s3_q <= '0;
      end else begin
         md_s1_q <= memory_data_in;
         md_s2_q <= md_s1_q;
         md_s3_q <= md_s2_q;
      end
   end

   // three-stage sync of the read level and the channel check line
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_s_q  <= `SYNC_CLR;
         chk_s_q <= `SYNC_SET;
      end else begin
         rd_s_q  <= {rd_s_q[1:0], mem_read};
         chk_s_q <= {chk_s_q[1:0], channel_check_in_n};
      end
   end

   // accept a level once second and third stage agree
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_q  <= 1'b0;
         chk_q <= 1'b1;
      end else begin
         if (rd_s_q[1] == rd_s_q[2])
            rd_q <= rd_s_q[2];
         if (chk_s_q[1] == chk_s_q[2])
            chk_q <= chk_s_q[2];
      end
   end

   // read side check of the sampled byte lanes
   assign lanes_rd.data   = md_s3_q;
   assign lanes_rd.par_in = par_s3_q;
   parity_calc u_chk (
      .lanes (lanes_rd)
   );

   // write side generation from the write data
   assign lanes_wr.data   = write_data;
   assign lanes_wr.par_in = `LANE_NONE;
   parity_calc u_gen (
      .lanes (lanes_wr)
   );

   // error only in enabled bytes during a read; the third read stage falls together
   // with the sampled data, so a bus released at the end of a read never faults
   assign any_err = rd_q && rd_s_q[2] && |(lanes_rd.mismatch & ~en_s3_q);

   // read tracking: an error after the first read cycle latches the fault until the read ends
   // so one bad word is not lost while a long read is still in progress
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
      end else if (sys_rst) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (rd_q)
                  state_q <= ST_READ;
            end
            ST_READ: begin
               if (any_err)
                  state_q <= ST_FAULT;
               else if (!rd_q)
                  state_q <= ST_IDLE;
            end
            ST_FAULT: begin
               if (!rd_q && !any_err)
                  state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // registered fault output, also set by error in the first read cycle
   // system reset wins over a standing error
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         fault_q <= 1'b0;
      else if (sys_rst)
         fault_q <= 1'b0;
      else
         fault_q <= any_err || (state_q == ST_FAULT && rd_q);
   end

   // nmi disable bit, set wins over clear, disabled after reset
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         nmi_off_q <= `NMI_OFF_RST;
      else if (sys_rst)
         nmi_off_q <= `NMI_OFF_RST;
      else if (nmi_disable_set)
         nmi_off_q <= 1'b1;
      else if (nmi_disable_clr)
         nmi_off_q <= 1'b0;
   end

   // pin outputs
   assign parity_fault_out_n = fault_q ? 1'b0 : `PFLT_IDLE;
   assign nmi_disabled       = nmi_off_q;
   // open collector: enable low pulls the line low
   assign nmi_out  = 1'b0;
   assign nmi_oe_n = ~(!nmi_off_q && (!chk_q || fault_q));
   // card holds the line low; we only follow its level
   assign fault_clear_ack = chk_q;

   // drive enable, low only on a write cycle outside system reset
   function automatic logic drive_n(input logic wr, input logic rst);
      drive_n = ~(wr && !rst);
   endfunction

   // parity lines driven only on writes outside reset
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         byte_parity_out  <= `LANE_NONE;
         byte_parity_oe_n <= `OE_OFF;
      end else begin
         byte_parity_out  <= lanes_wr.gen;
         byte_parity_oe_n <= drive_n(mem_write, sys_rst);
      end
   end

   // data lines share the write window and three-state otherwise
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         memory_data_out  <= '0;
         memory_data_oe_n <= `OE_OFF;
      end else begin
         memory_data_out  <= write_data;
         memory_data_oe_n <= drive_n(mem_write, sys_rst);
      end
   end
endmodule
`default_nettype wire

// ===== bench/memory_parity_nmi_logic_properties.sv
// Purpose: port checks on the parity and NMI block
// Assumes: one clock, async active-low reset
// Notes:   bound to the top module below
`timescale 1ns/1ns
`default_nettype none
module mpn_checker
   import parity_pkg::*;
(
   // watched ports
   input wire logic  clk_sys,
   input wire logic  resetn,
   input wire logic  system_reset_in,
   input wire logic  mem_read,
   input wire logic  mem_write,
   input wire word_t write_data,
   input wire logic  nmi_disable_set,
   input wire logic  channel_check_in_n,
   input wire logic  [31:0] memory_data_out,
   input wire logic  [3:0] byte_parity_out,
   input wire logic  memory_data_oe_n,
   input wire logic  byte_parity_oe_n,
   input wire logic  parity_fault_out_n,
   input wire logic  nmi_disabled,
   input wire logic  nmi_out,
   input wire logic  nmi_oe_n,
   input wire logic  fault_clear_ack
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // odd parity bit per byte lane
   function automatic lane_t oddp(word_t w);
      for (int i = 0; i < 4; i++)
         oddp[i] = ~^w[8*i+:8];
   endfunction
   property p_wr; mem_write && !system_reset_in |=> !byte_parity_oe_n && !memory_data_oe_n
      && byte_parity_out == oddp($past(write_data)) && memory_data_out == $past(write_data);
   endproperty
   a_wr: assert property (p_wr) else $error("write drive wrong");
   property p_flt; $fell(parity_fault_out_n) |-> $past(mem_read, 2); endproperty
   a_flt: assert property (p_flt) else $error("fault outside read");
   property p_idle; !mem_read [*8] |-> parity_fault_out_n; endproperty
   a_idle: assert property (p_idle) else $error("fault held idle");
   property p_mask; nmi_disabled |-> nmi_oe_n && !nmi_out; endproperty
   a_mask: assert property (p_mask) else $error("nmi not masked");
   property p_src; !nmi_disabled && !(parity_fault_out_n && fault_clear_ack) |-> !nmi_oe_n;
   endproperty
   a_src: assert property (p_src) else $error("nmi missing");
   property p_cause; !nmi_oe_n |-> !(parity_fault_out_n && fault_clear_ack); endproperty
   a_cause: assert property (p_cause) else $error("nmi no cause");
   property p_dis; nmi_disable_set && !system_reset_in |=> nmi_disabled; endproperty
   a_dis: assert property (p_dis) else $error("disable lost");
   property p_rst; system_reset_in |=> parity_fault_out_n && byte_parity_oe_n
      && memory_data_oe_n && nmi_disabled;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_chk; !channel_check_in_n [*5] |-> !fault_clear_ack; endproperty
   a_chk: assert property (p_chk) else $error("card check not followed");
endmodule
bind memory_parity_nmi_logic mpn_checker u_props (.clk_sys, .resetn, .system_reset_in,
   .mem_read, .mem_write, .write_data, .nmi_disable_set, .channel_check_in_n,
   .memory_data_out, .byte_parity_out, .memory_data_oe_n, .byte_parity_oe_n,
   .parity_fault_out_n, .nmi_disabled, .nmi_out, .nmi_oe_n, .fault_clear_ack);
`default_nettype wire

// ===== bench/dram_model.sv
// Purpose: one-word memory behind the parity lines
// Assumes: stores whatever the block drives
// Notes:   flip corrupts parity lanes on reads
`timescale 1ns/1ns
`default_nettype none
module dram_model (
   // from the block, with clock, read and flip from the bench
   input wire logic        clk_sys,
   input wire logic        rd,
   input wire logic [31:0] d_out,
   input wire logic [3:0]  p_out,
   input wire logic        oe_n,
   input wire logic [3:0]  flip,
   // to the block
   output logic [31:0] d_in,
   output logic [3:0]  p_in
);
   logic [31:0] mem_q = 32'h0;
   logic [3:0]  par_q = 4'h0;
   // capture a write while the block drives
   always_ff @(posedge clk_sys) begin
      if (!oe_n) begin
         mem_q <= d_out;
         par_q <= p_out;
      end
   end
   // released bus shows the inverse of the last word
   assign d_in = rd ? mem_q : ~mem_q;
   assign p_in = rd ? par_q ^ flip : ~par_q;
endmodule
`default_nettype wire

// ===== bench/memory_parity_nmi_logic_test.sv
// Purpose: self-checking bench for the parity and NMI block
// Assumes: 100 MHz clock
// Notes:   table of write then read cycles, then hand tests
`timescale 1ns/1ns
`default_nettype none
module memory_parity_nmi_logic_test;
   import parity_pkg::*;
   logic clk_sys = 0, resetn = 0, system_reset_in = 0, mem_read = 0, mem_write = 0;
   logic channel_check_in_n = 1, nmi_disable_set = 0, nmi_disable_clr = 0;
   logic memory_data_oe_n, byte_parity_oe_n, parity_fault_out_n, nmi_disabled;
   logic nmi_out, nmi_oe_n, fault_clear_ack;
   word_t write_data = 32'h0, memory_data_in, memory_data_out;
   lane_t byte_check_enable_n = 4'hF, flip = 4'h0, byte_parity_in, byte_parity_out;
   int n_fail = 0, checks_done = 0;
   typedef struct packed {word_t d; lane_t par, flip, en_n; logic flt;} row_s;
   row_s rows[5] = '{'{32'h00000000, 4'hF, 4'h0, 4'h0, 1'h0},
      '{32'h12345678, 4'hB, 4'h1, 4'h0, 1'h1}, '{32'hFFFFFFFF, 4'hF, 4'h8, 4'h7, 1'h1},
      '{32'hA5A5A5A5, 4'hF, 4'hF, 4'hF, 1'h0}, '{32'h80FF0001, 4'h6, 4'h6, 4'h9, 1'h1}};
   always #5 clk_sys = ~clk_sys;
   memory_parity_nmi_logic dut (.clk_sys, .resetn, .system_reset_in, .memory_data_in,
      .memory_data_out, .memory_data_oe_n, .write_data, .byte_parity_in, .byte_parity_out,
      .byte_parity_oe_n, .mem_read, .mem_write, .byte_check_enable_n, .channel_check_in_n,
      .parity_fault_out_n, .nmi_disable_set, .nmi_disable_clr, .nmi_disabled, .nmi_out,
      .nmi_oe_n, .fault_clear_ack);
   dram_model mem (.clk_sys, .rd(mem_read), .d_out(memory_data_out), .p_out(byte_parity_out),
      .oe_n(memory_data_oe_n), .flip, .d_in(memory_data_in), .p_in(byte_parity_in));
   task automatic chk(logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // wait n rising edges, then the following falling edge
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   initial begin
      tick(5);
      @(posedge clk_sys) resetn <= 1;
      tick(1);
      chk(nmi_disabled, 1);
      chk({parity_fault_out_n, nmi_oe_n}, 2'h3);
      chk({byte_parity_oe_n, memory_data_oe_n}, 2'h3);
      @(posedge clk_sys) nmi_disable_clr <= 1;
      @(posedge clk_sys) nmi_disable_clr <= 0;
      foreach (rows[i]) begin
         @(posedge clk_sys) mem_write <= 1;
         write_data <= rows[i].d;
         @(posedge clk_sys) mem_write <= 0;
         @(negedge clk_sys);
         chk(byte_parity_out, rows[i].par);
         chk(memory_data_out, rows[i].d);
         chk({byte_parity_oe_n, memory_data_oe_n}, 2'h0);
         @(posedge clk_sys) mem_read <= 1;
         flip <= rows[i].flip;
         byte_check_enable_n <= rows[i].en_n;
         tick(7);
         chk(parity_fault_out_n, !rows[i].flt);
         chk(nmi_oe_n, !rows[i].flt);
         @(posedge clk_sys) mem_read <= 0;
         tick(8);
         chk(parity_fault_out_n, 1);
      end
      // system reset in mid read with a fault standing, held while the read ends
      @(posedge clk_sys) mem_read <= 1;
      tick(7);
      chk(parity_fault_out_n, 0);
      @(posedge clk_sys) system_reset_in <= 1;
      tick(1);
      chk(parity_fault_out_n, 1);
      chk(nmi_disabled, 1);
      @(posedge clk_sys) mem_read <= 0;
      flip <= 4'h0;
      tick(6);
      chk({parity_fault_out_n, nmi_oe_n}, 2'h3);
      @(posedge clk_sys) system_reset_in <= 0;
      nmi_disable_clr <= 1;
      // card holds channel check low until cleared
      @(posedge clk_sys) nmi_disable_clr <= 0;
      channel_check_in_n <= 0;
      tick(8);
      chk(fault_clear_ack, 0);
      chk(parity_fault_out_n, 1);
      chk(nmi_oe_n, 0);
      chk(nmi_out, 0);
      // set and clear in one cycle: set wins and masks the card's request
      @(posedge clk_sys) nmi_disable_set <= 1;
      nmi_disable_clr <= 1;
      @(posedge clk_sys) nmi_disable_set <= 0;
      nmi_disable_clr <= 0;
      @(negedge clk_sys);
      chk(nmi_disabled, 1);
      chk(nmi_oe_n, 1);
      @(posedge clk_sys) channel_check_in_n <= 1;
      tick(8);
      chk(fault_clear_ack, 1);
      conclude();
   end
   // watchdog: the tests need about 150 cycles, so 500 cycles means a hang
   initial begin
      #5000;
      n_fail++;
      conclude();
   end
endmodule
`default_nettype wire
